//--- dtc_top.sv
// dtc_top.sv: dual timer/counter with AHB-Lite register slave
// assumes: single hclk domain at 200 MHz, the only slave on its AHB-Lite bus
//
// Behaviour
// RQ1: two 16-bit timers; each may count falling edges of its count pin instead.
// RQ2: tick is clock divided by 12, or undivided when fast select is set.
// RQ3: gate clear counts on run bit; gate set also needs gate pin high.
// RQ4: function bit 0 counts internal ticks, 1 counts external pin events.
// RQ5: mode field 00 13-bit, 01 16-bit, 10 8-bit reload, 11 split/stop.
// RQ6: mode 0 counts 13 bits; rollover to zero sets overflow flag.
// RQ7: mode 1 like mode 0 but all 16 bits count.
// RQ8: mode 2 low byte counts; overflow sets flag, reloads low from high.
// RQ9: timer one in mode 3 stops and holds its count.
// RQ10: timer zero mode 3 splits; low byte uses timer zero controls and flag.
// RQ11: split high byte counts ticks, runs on run bit one, sets flag one.
// RQ12: overflow flags set by hardware, cleared when the core vectors.
// RQ13: run bit 0 stops counting, 1 starts it; resets to 0.
// RQ14: external request flags set by pin requests, cleared on vectoring.
// RQ15: trigger type 0 means low level, 1 means falling edge.
// RQ16: software writes to flags act like hardware set or clear; writes never set ists, and level-mode request flags ignore them.
// RQ17: vectoring clears external flag only in edge mode; level follows pin.
// RQ18: pins synchronised; falling edge found by comparing successive samples.
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dtc_top
  import dtc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [1:0]  ext_count_pin,
  input  wire logic [1:0]  ext_gate_pin,
  output logic             irq
);
  dtc_state_t s_ff;
  dtc_state_t nxt_s;
  logic       presc_tick;
  logic [3:0] pin_lvl;
  logic [3:0] pin_fall;
  logic [1:0] t_en;
  logic [1:0] gate_ok;
  logic [1:0] cnt_en;
  logic       tf0_set;
  logic       tf1_set;
  logic [1:0] ie_set;
  logic [16:0] step0;
  logic [16:0] step1;
  logic [8:0]  split_lo;
  logic [8:0]  split_hi;
  logic [3:0]  ack;
  logic        addr_ok;

  // ********************
  // helpers
  // ********************
  // one count step for modes 0..2: {overflow, high byte, low byte}
  function automatic logic [16:0] dtc_step(input logic [1:0] m,
                                           input logic [7:0] tl,
                                           input logic [7:0] th);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    logic [16:0] r;
    begin
      s13 = {1'b0, th, tl[4:0]} + 14'h0001;
      s16 = {1'b0, th, tl} + 17'h00001;
      s8 = {1'b0, tl} + 9'h001;
      case (m)
        DTC_M13: r = {s13[13], s13[12:5], tl[7:5], s13[4:0]}; // see RQ6
        DTC_M16: r = s16; // see RQ7
        DTC_M8R: r = s8[8] ? {1'b1, th, th} : {1'b0, th, s8[7:0]}; // see RQ8
        default: r = {1'b0, th, tl};
      endcase
      return r;
    end
  endfunction

  function automatic logic [31:0] dtc_read(input logic [7:0] a,
                                           input dtc_state_t v);
    logic [31:0] r;
    begin
      r = 32'h0000_0000;
      case (a)
        `DTC_OFS_MODE: r = {24'h00_0000, v.mode};
        `DTC_OFS_CTL:  r = {24'h00_0000, v.ctl};
        `DTC_OFS_AUX:  r = {24'h00_0000, v.fast, 6'h00};
        `DTC_OFS_TL0:  r = {24'h00_0000, v.tl0};
        `DTC_OFS_TH0:  r = {24'h00_0000, v.th0};
        `DTC_OFS_TL1:  r = {24'h00_0000, v.tl1};
        `DTC_OFS_TH1:  r = {24'h00_0000, v.th1};
        `DTC_OFS_ISTS: r = {28'h000_0000, v.ists};
        `DTC_OFS_IMSK: r = {28'h000_0000, v.imsk};
        default:       r = 32'h0000_0000;
      endcase
      return r;
    end
  endfunction

  // ********************
  // submodules
  // ********************
  dtc_presc u_presc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .tick    (presc_tick)
  );

  dtc_sync u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin     ({ext_gate_pin, ext_count_pin}),
    .lvl     (pin_lvl),
    .fall    (pin_fall)
  );

  // ********************
  // next state
  // ********************
  always_comb
  begin
    nxt_s = s_ff;
    ack = 4'h0;
    tf0_set = 1'b0;
    tf1_set = 1'b0;
    nxt_s.ready = 1'b1;
    nxt_s.resp = 1'b0;
    // count enables per unit
    t_en[0] = s_ff.fast[1] | presc_tick; // see RQ2
    t_en[1] = s_ff.fast[0] | presc_tick; // see RQ2
    gate_ok[0] = ~s_ff.mode[`DTC_GATE0] | pin_lvl[2]; // see RQ3
    gate_ok[1] = ~s_ff.mode[`DTC_GATE1] | pin_lvl[3]; // see RQ3
    cnt_en[0] = s_ff.ctl[`DTC_RUN0] & gate_ok[0] & // see RQ13
                (s_ff.mode[`DTC_FUNC0] ? pin_fall[0] : t_en[0]); // see RQ4
    cnt_en[1] = s_ff.ctl[`DTC_RUN1] & gate_ok[1] & // see RQ13
                (s_ff.mode[`DTC_FUNC1] ? pin_fall[1] : t_en[1]); // see RQ4
    step0 = dtc_step(s_ff.mode[1:0], s_ff.tl0, s_ff.th0); // see RQ1
    step1 = dtc_step(s_ff.mode[5:4], s_ff.tl1, s_ff.th1); // see RQ1
    split_lo = {1'b0, s_ff.tl0} + 9'h001;
    split_hi = {1'b0, s_ff.th0} + 9'h001;
    // unit zero, mode field decides the layout
    if (s_ff.mode[1:0] == DTC_MSP)
    begin
      if (cnt_en[0])
      begin
        nxt_s.tl0 = split_lo[7:0]; // see RQ10
        tf0_set = split_lo[8]; // see RQ10
      end
      // high half: internal tick only, run bit one, flag one
      if (s_ff.ctl[`DTC_RUN1] && t_en[0])
      begin
        nxt_s.th0 = split_hi[7:0]; // see RQ11
        tf1_set = split_hi[8]; // see RQ11
      end
    end
    else if (cnt_en[0])
    begin
      {nxt_s.th0, nxt_s.tl0} = step0[15:0]; // see RQ5
      tf0_set = step0[16]; // see RQ6
    end
    // unit one holds in mode 3
    if (s_ff.mode[5:4] != DTC_MSP && cnt_en[1]) // see RQ9
    begin
      {nxt_s.th1, nxt_s.tl1} = step1[15:0]; // see RQ5
      // its flag belongs to the split high half while unit zero is split
      if (s_ff.mode[1:0] != DTC_MSP)
        tf1_set = step1[16]; // see RQ7
    end
    ie_set[0] = s_ff.ctl[`DTC_IT0] ? pin_fall[2] : ~pin_lvl[2]; // see RQ15
    ie_set[1] = s_ff.ctl[`DTC_IT1] ? pin_fall[3] : ~pin_lvl[3]; // see RQ15
    // data phase of a write; a write to a count wins over counting
    if (s_ff.wr_pend)
    begin
      case (s_ff.wr_addr)
        `DTC_OFS_MODE: nxt_s.mode = hwdata[7:0];
        `DTC_OFS_CTL:  nxt_s.ctl = hwdata[7:0]; // see RQ16
        `DTC_OFS_AUX:  nxt_s.fast = hwdata[7:6];
        `DTC_OFS_TL0:  nxt_s.tl0 = hwdata[7:0];
        `DTC_OFS_TH0:  nxt_s.th0 = hwdata[7:0];
        `DTC_OFS_TL1:  nxt_s.tl1 = hwdata[7:0];
        `DTC_OFS_TH1:  nxt_s.th1 = hwdata[7:0];
        `DTC_OFS_ACK:  ack = hwdata[3:0];
        `DTC_OFS_ISTS: nxt_s.ists = s_ff.ists & ~hwdata[3:0];
        `DTC_OFS_IMSK: nxt_s.imsk = hwdata[3:0];
        default:       ack = 4'h0;
      endcase
    end
    // vectoring acknowledge: bit0 ext0, bit1 tf0, bit2 ext1, bit3 tf1
    if (ack[1])
      nxt_s.ctl[`DTC_TF0] = 1'b0; // see RQ12
    if (ack[3])
      nxt_s.ctl[`DTC_TF1] = 1'b0; // see RQ12
    if (ack[0] && s_ff.ctl[`DTC_IT0])
      nxt_s.ctl[`DTC_IE0] = 1'b0; // see RQ17
    if (ack[2] && s_ff.ctl[`DTC_IT1])
      nxt_s.ctl[`DTC_IE1] = 1'b0; // see RQ17
    // hardware set wins over any clear in the same cycle
    if (tf0_set)
      nxt_s.ctl[`DTC_TF0] = 1'b1; // see RQ12
    if (tf1_set)
      nxt_s.ctl[`DTC_TF1] = 1'b1; // see RQ12
    // level mode: the pin owns the flag, software writes do not stick
    if (s_ff.ctl[`DTC_IT0])
      nxt_s.ctl[`DTC_IE0] = nxt_s.ctl[`DTC_IE0] | ie_set[0]; // see RQ14
    else
      nxt_s.ctl[`DTC_IE0] = ie_set[0]; // see RQ17
    if (s_ff.ctl[`DTC_IT1])
      nxt_s.ctl[`DTC_IE1] = nxt_s.ctl[`DTC_IE1] | ie_set[1]; // see RQ14
    else
      nxt_s.ctl[`DTC_IE1] = ie_set[1]; // see RQ17
    nxt_s.ists = nxt_s.ists | {tf1_set, ie_set[1], tf0_set, ie_set[0]};
    nxt_s.irq = |(nxt_s.ists & nxt_s.imsk);
    // address phase
    addr_ok = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'h0);
    nxt_s.wr_pend = 1'b0;
    if (hsel && hready && htrans[1])
    begin
      if (hwrite)
      begin
        nxt_s.wr_pend = addr_ok;
        nxt_s.wr_addr = haddr[7:0];
      end
      else
      begin
        // read sees the state as it stands after this cycle's updates
        nxt_s.rdata = addr_ok ? dtc_read(haddr[7:0], nxt_s) : 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_ff <= '0;
      s_ff.ready <= 1'b1;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign hrdata = s_ff.rdata;
  assign hreadyout = s_ff.ready;
  assign hresp = s_ff.resp;
  assign irq = s_ff.irq;

  // ********************
  // assertions
  // ********************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_edge_counted;
    s_ff.mode[`DTC_FUNC1] && pin_fall[1] && s_ff.ctl[`DTC_RUN1] && gate_ok[1]
      && s_ff.mode[5:4] == DTC_M16 && !s_ff.wr_pend;
  endsequence

  sequence s_split_hi_wrap;
    s_ff.mode[1:0] == DTC_MSP && s_ff.ctl[`DTC_RUN1] && t_en[0]
      && s_ff.th0 == 8'hff && !s_ff.wr_pend;
  endsequence

  a_tick_period: assert property (presc_tick |-> ##12 presc_tick) // see RQ2
    else $error("prescale tick period is not 12");
  a_tick_quiet: assert property (presc_tick |=> !presc_tick [*8]) // see RQ2
    else $error("prescale tick repeats early");
  a_stop_holds: assert property ((!s_ff.ctl[`DTC_RUN0] && !s_ff.wr_pend // see RQ13
    && s_ff.mode[1:0] != DTC_MSP) |=> $stable({s_ff.th0, s_ff.tl0}))
    else $error("stopped unit zero changed");
  a_gate_blocks: assert property ((s_ff.mode[`DTC_GATE0] && !pin_lvl[2] // see RQ3
    && !s_ff.wr_pend && s_ff.mode[1:0] != DTC_MSP) |=> $stable({s_ff.th0, s_ff.tl0}))
    else $error("gated unit zero counted");
  a_edge_count: assert property (s_edge_counted |=> // see RQ18
    {s_ff.th1, s_ff.tl1} == $past({s_ff.th1, s_ff.tl1}) + 16'h0001)
    else $error("pin edge did not count once");
  a_reload_low: assert property ((s_ff.mode[1:0] == DTC_M8R && cnt_en[0] // see RQ8
    && s_ff.tl0 == 8'hff && !s_ff.wr_pend)
    |=> s_ff.tl0 == $past(s_ff.th0) && s_ff.ctl[`DTC_TF0] && $stable(s_ff.th0))
    else $error("mode 2 reload wrong");
  a_one_holds: assert property ((s_ff.mode[5:4] == DTC_MSP && !s_ff.wr_pend) // see RQ9
    |=> $stable({s_ff.th1, s_ff.tl1}))
    else $error("unit one moved in mode 3");
  a_split_high: assert property (s_split_hi_wrap |=> // see RQ11
    s_ff.th0 == 8'h00 && s_ff.ctl[`DTC_TF1] && s_ff.ists[3])
    else $error("split high wrap missed flag one");
  a_ack_clears: assert property ((s_ff.wr_pend && s_ff.wr_addr == `DTC_OFS_ACK // see RQ12
    && hwdata[1] && !tf0_set) |=> !s_ff.ctl[`DTC_TF0])
    else $error("vector ack left flag zero set");
  a_level_flag: assert property (!s_ff.ctl[`DTC_IT0] |=> // see RQ17
    s_ff.ctl[`DTC_IE0] == !$past(pin_lvl[2]))
    else $error("level flag does not follow pin");
  a_edge_flag: assert property ((s_ff.ctl[`DTC_IT1] && pin_fall[3]) // see RQ15
    |=> s_ff.ctl[`DTC_IE1] ##1 (s_ff.ctl[`DTC_IE1] || !$past(s_ff.wr_pend)))
    else $error("edge request lost");
endmodule

//--- dtc_consts.svh
// dtc_consts.svh: register offsets, field positions, reset values, timing
// assumes: included by bare name from the top and prescaler design files and from the bench
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH
// ********************
// register offsets
// ********************
`define DTC_OFS_MODE 8'h00
`define DTC_OFS_CTL  8'h04
`define DTC_OFS_AUX  8'h08
`define DTC_OFS_TL0  8'h0c
`define DTC_OFS_TH0  8'h10
`define DTC_OFS_TL1  8'h14
`define DTC_OFS_TH1  8'h18
`define DTC_OFS_ACK  8'h1c
`define DTC_OFS_ISTS 8'h20
`define DTC_OFS_IMSK 8'h24
// ********************
// field positions
// ********************
`define DTC_GATE0 3
`define DTC_FUNC0 2
`define DTC_GATE1 7
`define DTC_FUNC1 6
`define DTC_TF1   7
`define DTC_RUN1  6
`define DTC_TF0   5
`define DTC_RUN0  4
`define DTC_IE1   3
`define DTC_IT1   2
`define DTC_IE0   1
`define DTC_IT0   0
`define DTC_FAST0 7
`define DTC_FAST1 6
// ********************
// reset values and timing
// ********************
`define DTC_RST_BYTE 8'h00
`define DTC_TICK_DIV 4'hc
`endif

//--- dtc_pkg.sv
// dtc_pkg.sv: types shared by the timer block modules
// assumes: nothing outside itself
package dtc_pkg;
  typedef enum logic [1:0] {
    DTC_M13 = 2'h0,
    DTC_M16 = 2'h1,
    DTC_M8R = 2'h2,
    DTC_MSP = 2'h3
  } dtc_mode_t;
  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } dtc_presc_t;
  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] fall;
  } dtc_sync_t;
  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  ctl;
    logic [1:0]  fast;
    logic [7:0]  tl0;
    logic [7:0]  th0;
    logic [7:0]  tl1;
    logic [7:0]  th1;
    logic [3:0]  ists;
    logic [3:0]  imsk;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic [31:0] rdata;
    logic        irq;
    logic        ready;
    logic        resp;
  } dtc_state_t;
endpackage

//--- dtc_presc.sv
// dtc_presc.sv: divide-by-12 count tick for timer function
// assumes: one free running clock, asynchronous active low reset
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dtc_presc
  import dtc_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      tick
);
  dtc_presc_t s_ff;
  dtc_presc_t nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    if (s_ff.cnt == (`DTC_TICK_DIV - 4'h1))
    begin
      nxt_s.cnt = 4'h0;
      nxt_s.tick = 1'b1;
    end
    else
    begin
      nxt_s.cnt = s_ff.cnt + 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_ff <= '0;
    else
      s_ff <= nxt_s;
  end

  assign tick = s_ff.tick;
endmodule

//--- dtc_sync.sv
// dtc_sync.sv: three-stage synchronisers and falling edge pulses for pins
// assumes: pins are asynchronous to hclk; index 0,1 count pins, 2,3 gate pins
`timescale 1ns/1ps
module dtc_sync
  import dtc_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [3:0] pin,
  output logic [3:0]      lvl,
  output logic [3:0]      fall
);
  dtc_sync_t s_ff;
  dtc_sync_t nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.s1 = pin;
    nxt_s.s2 = s_ff.s1;
    nxt_s.s3 = s_ff.s2;
    // compare two settled samples only; s1 may be metastable
    nxt_s.fall = s_ff.s3 & ~s_ff.s2; // see RQ18
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_ff <= {4'hf, 4'hf, 4'hf, 4'h0};
    else
      s_ff <= nxt_s;
  end

  assign lvl = s_ff.s3;
  assign fall = s_ff.fall;
endmodule

//--- dtc_pins.sv
// dtc_pins.sv: model of the external count and gate pins
// assumes: its tasks are called just after a rising edge of hclk
`timescale 1ns/1ps
module dtc_pins
(
  input  wire logic  hclk,
  output logic [1:0] ext_count_pin,
  output logic [1:0] ext_gate_pin
);
  // [1:0] count pins, [3:2] gate pins; idle high so no request is raised
  logic [3:0] pins_q = 4'hf;
  assign ext_count_pin = pins_q[1:0];
  assign ext_gate_pin  = pins_q[3:2];
  task automatic set(input logic [3:0] sel, input logic lvl);
    pins_q <= lvl ? (pins_q | sel) : (pins_q & ~sel);
  endtask
  // four clocks a level: the synchroniser needs at least two
  task automatic pulse(input logic [3:0] sel, input int n);
    repeat (n)
    begin
      set(sel, 1'b0);
      repeat (4) @(posedge hclk);
      set(sel, 1'b1);
      repeat (4) @(posedge hclk);
    end
  endtask
endmodule

//--- dual_timer_counter_four_modes_test.sv
// dual_timer_counter_four_modes_test.sv: self-checking bench of the timer block
// assumes: dtc_top is the only AHB-Lite slave; pins come from dtc_pins
`timescale 1ns/1ps
`include "dtc_consts.svh"
module dual_timer_counter_four_modes_test;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [1:0]  ext_count_pin;
  logic [1:0]  ext_gate_pin;
  logic        irq;
  logic [31:0] v;
  int          errors;
  int          n_tests;
  dtc_top dut (
    .hclk          (hclk),
    .hresetn       (hresetn),
    .hsel          (hsel),
    .haddr         (haddr),
    .htrans        (htrans),
    .hwrite        (hwrite),
    .hsize         (3'h2),
    .hwdata        (hwdata),
    .hready        (hreadyout),
    .hrdata        (hrdata),
    .hreadyout     (hreadyout),
    .hresp         (hresp),
    .ext_count_pin (ext_count_pin),
    .ext_gate_pin  (ext_gate_pin),
    .irq           (irq)
  );
  dtc_pins pins (
    .hclk          (hclk),
    .ext_count_pin (ext_count_pin),
    .ext_gate_pin  (ext_gate_pin)
  );
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // ********************
  // reporting
  // ********************
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  // ********************
  // bus cycles
  // ********************
  task automatic rdy();
    int k;
    k = 0;
    do
    begin
      @(posedge hclk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 100);
    if (hreadyout !== 1'b1)
    begin
      errors++;
      conclude();
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    v = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(v, e);
  endtask
  // bounded wait for a flag, read back over the bus
  task automatic poll(input logic [7:0] a, input int b);
    int k;
    k = 0;
    do
    begin
      xfer(1'b0, a, 32'h0);
      k++;
    end
    while (v[b] !== 1'b1 && k < 200);
    chk({31'h0, v[b]}, 32'h1);
    if (v[b] !== 1'b1)
      conclude();
  endtask
  task automatic ovf0(input logic [7:0] tl, input logic [7:0] th, input logic [7:0] md);
    wr(`DTC_OFS_TL0, {24'h0, tl});
    wr(`DTC_OFS_TH0, {24'h0, th});
    wr(`DTC_OFS_MODE, {24'h0, md});
    wr(`DTC_OFS_CTL, 32'h10);
    poll(`DTC_OFS_CTL, `DTC_TF0);
  endtask
  // ********************
  // tests
  // ********************
  initial
  begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'h0;
    hwrite  = 1'b0;
    hwdata  = 32'h0;
    errors  = 0;
    n_tests = 0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(`DTC_OFS_MODE, 32'h0);
    rc(`DTC_OFS_CTL, 32'h0);
    rc(`DTC_OFS_AUX, 32'h0);
    wr(8'h40, 32'hff);
    rc(8'h40, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    done("reset");
    wr(`DTC_OFS_AUX, 32'h80);
    ovf0(8'hfe, 8'hff, 8'h01);
    wr(`DTC_OFS_CTL, 32'h0);
    rc(`DTC_OFS_CTL, 32'h0);
    rc(`DTC_OFS_TH0, 32'h0);
    done("mode 1");
    ovf0(8'h1f, 8'hff, 8'h00);
    wr(`DTC_OFS_CTL, 32'h0);
    rc(`DTC_OFS_TH0, 32'h0);
    xfer(1'b0, `DTC_OFS_ISTS, 32'h0);
    chk({31'h0, v[1]}, 32'h1);
    xfer(1'b0, `DTC_OFS_TL0, 32'h0);
    chk({24'h0, v[7:0] & 8'he0}, 32'h0);
    done("mode 0");
    ovf0(8'hfe, 8'h80, 8'h02);
    wr(`DTC_OFS_ACK, 32'h2);
    rc(`DTC_OFS_CTL, 32'h10);
    wr(`DTC_OFS_CTL, 32'h0);
    rc(`DTC_OFS_TH0, 32'h80);
    xfer(1'b0, `DTC_OFS_TL0, 32'h0);
    chk({31'h0, v[7]}, 32'h1);
    done("mode 2");
    wr(`DTC_OFS_TL0, 32'h0);
    wr(`DTC_OFS_MODE, 32'h01);
    wr(`DTC_OFS_AUX, 32'h0);
    wr(`DTC_OFS_CTL, 32'h10);
    repeat (120) @(posedge hclk);
    wr(`DTC_OFS_CTL, 32'h0);
    xfer(1'b0, `DTC_OFS_TL0, 32'h0);
    chk({31'h0, v >= 32'd9 && v <= 32'd11}, 32'h1);
    done("divide");
    wr(`DTC_OFS_MODE, 32'h09);
    wr(`DTC_OFS_AUX, 32'h80);
    wr(`DTC_OFS_TL0, 32'h0);
    pins.set(4'h4, 1'b0);
    // let the low level reach the synchroniser output before running
    repeat (4) @(posedge hclk);
    wr(`DTC_OFS_CTL, 32'h10);
    repeat (20) @(posedge hclk);
    rc(`DTC_OFS_TL0, 32'h0);
    wr(`DTC_OFS_ACK, 32'h1);
    rc(`DTC_OFS_CTL, 32'h12);
    pins.set(4'h4, 1'b1);
    repeat (20) @(posedge hclk);
    xfer(1'b0, `DTC_OFS_TL0, 32'h0);
    chk({31'h0, v >= 32'd12}, 32'h1);
    wr(`DTC_OFS_CTL, 32'h0);
    rc(`DTC_OFS_CTL, 32'h0);
    done("gate");
    wr(`DTC_OFS_CTL, 32'h04);
    pins.pulse(4'h8, 1);
    rc(`DTC_OFS_CTL, 32'h0c);
    wr(`DTC_OFS_ACK, 32'h4);
    rc(`DTC_OFS_CTL, 32'h04);
    wr(`DTC_OFS_CTL, 32'h0c);
    rc(`DTC_OFS_CTL, 32'h0c);
    wr(`DTC_OFS_CTL, 32'h0);
    done("edge request");
    rc(`DTC_OFS_ISTS, 32'h7);
    chk({31'h0, irq}, 32'h0);
    wr(`DTC_OFS_IMSK, 32'h2);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h1);
    wr(`DTC_OFS_ISTS, 32'h2);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq}, 32'h0);
    rc(`DTC_OFS_ISTS, 32'h5);
    wr(`DTC_OFS_ISTS, 32'h5);
    rc(`DTC_OFS_ISTS, 32'h0);
    done("interrupt");
    wr(`DTC_OFS_TL1, 32'h0);
    wr(`DTC_OFS_MODE, 32'h50);
    wr(`DTC_OFS_CTL, 32'h40);
    pins.pulse(4'h2, 3);
    repeat (4) @(posedge hclk);
    rc(`DTC_OFS_TL1, 32'h3);
    done("counter");
    wr(`DTC_OFS_MODE, 32'h33);
    wr(`DTC_OFS_TL0, 32'h0);
    wr(`DTC_OFS_TH0, 32'hfe);
    poll(`DTC_OFS_CTL, `DTC_TF1);
    wr(`DTC_OFS_CTL, 32'h0);
    rc(`DTC_OFS_TL0, 32'h0);
    rc(`DTC_OFS_TL1, 32'h3);
    done("split");
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc(`DTC_OFS_MODE, 32'h0);
    rc(`DTC_OFS_CTL, 32'h0);
    rc(`DTC_OFS_ISTS, 32'h0);
    done("reset again");
    conclude();
  end
endmodule
